/* File: rtl/tbw_params.svh */
// Constants for the ten-bit-address write controller
`ifndef TBW_PARAMS_SVH
`define TBW_PARAMS_SVH
`define TBW_EXT_ADDR_PATTERN 5'h1_E
`define TBW_DIR_WRITE 1'h0
`define TBW_BYTE_BITS 4'h8
`define TBW_HALF_BIT_NS 2000
`define TBW_CLK_NS 4
`define TBW_HALF_BIT_CYC (`TBW_HALF_BIT_NS / `TBW_CLK_NS)
`define TBW_SETUP_CYC 16'h0_004
`endif

/* File: rtl/tbw_pkg.sv */
// Types shared by the ten-bit-address write controller
package tbw_pkg;
    typedef enum logic [3:0] {
        TBW_IDLE = 4'b0000,
        TBW_START = 4'b0001,
        TBW_LOAD = 4'b0010,
        TBW_SHIFT = 4'b0011,
        TBW_ACK = 4'b0100,
        TBW_HOLD = 4'b0101,
        TBW_STOP_LOW = 4'b0110,
        TBW_STOP_HIGH = 4'b0111,
        TBW_STOP_END = 4'b1000
    } tbw_state_type;
endpackage

/* File: rtl/tbw_bit_timer.sv */
// Half-bit tick generator for the serial clock
`timescale 1ns/1ps
`include "tbw_params.svh"
module tbw_bit_timer (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic run_in,
    output logic tick_out
);
    logic [15:0] count;
    // Restart on idle so the first phase after start is whole; later phases share the running count
    always_ff @(posedge core_clk_in) begin
        if (rst_in || !run_in) begin
            count <= 16'h0_000;
            tick_out <= 1'b0;
        end else if (count == 16'(`TBW_HALF_BIT_CYC - 1)) begin
            count <= 16'h0_000;
            tick_out <= 1'b1;
        end else begin
            count <= count + 16'h0_001;
            tick_out <= 1'b0;
        end
    end
endmodule // tbw_bit_timer

/* File: rtl/tbw_master.sv */
// Two-wire bus master: write sequencing for a ten-bit slave address
`timescale 1ns/1ps
`include "tbw_params.svh"
// Functional notes
// R1: The shift register is loaded from the data register before each address byte, the second included.
// R2: The transmit interrupt rises once the first bit of the first address byte is on the data line.
// R3: Software answers the first transmit interrupt by writing the second address byte.
// R4: The rest of the first address byte and the write direction bit are shifted out.
// R5: A slave holding data low during the next clock-high period sets the acknowledge bit.
// R6: A missing acknowledge on the first byte sets the no-response flag and clears acknowledge.
// R7: Software answers a no-response flag with stop and flush and clears the transmit enable.
// R8: After no-response with stop, a stop condition is sent, then stop and the flag are cleared.
// R9: The transmit interrupt rises again after the first bit of the second address byte.
// R10: Software answers the second transmit interrupt by setting stop, optionally clearing the enable.
// R11: The stop bit clears only once the stop condition has been sent.
// R12: With stop requested a missing acknowledge raises no flag; acknowledge reads 1 or 0.
// R13: The first address byte is the extended pattern, the two upper address bits and direction.
module tbw_master (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic start_in,
    input wire logic [7:0] data_in,
    input wire logic data_wr_in,
    input wire logic stop_set_in,
    input wire logic flush_in,
    input wire logic transmit_irq_enable_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_oe_out,
    output logic sda_oe_out,
    output logic scl_out,
    output logic sda_out,
    output logic tx_irq_out,
    output logic ack_out,
    output logic no_response_irq_flag_out,
    output logic stop_out,
    output logic busy_out
);
    import tbw_pkg::*;

    tbw_state_type state;
    logic [7:0] data_reg;
    logic data_full;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic phase_high;
    logic byte_idx;
    logic tick;
    logic scl_m;
    logic scl_s;
    logic sda_m;
    logic sda_s;
    logic tx_req;

    // Form the first address byte from the upper two address bits
    function automatic logic [7:0] first_byte(input logic [1:0] hi);
        first_byte = {`TBW_EXT_ADDR_PATTERN, hi, `TBW_DIR_WRITE}; // [R13]
    endfunction

    tbw_bit_timer u_timer (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .run_in(state != TBW_IDLE),
        .tick_out(tick)
    );

    // Two-stage synchronisers; only the data line's second stage is read
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
        end else begin
            scl_m <= scl_in;
            scl_s <= scl_m;
            sda_m <= sda_in;
            sda_s <= sda_m;
        end
    end

    // Data register; software writes, loads into the shifter empty it
    always_ff @(posedge core_clk_in) begin
        if (rst_in || flush_in) begin
            data_reg <= 8'h0_0;
            data_full <= 1'b0;
        end else if (data_wr_in) begin
            data_reg <= data_in; // [R3]
            data_full <= 1'b1;
        end else if (state == TBW_LOAD && data_full) begin
            data_full <= 1'b0;
        end
    end

    // Sequencer: start, two address bytes, acknowledge, stop
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            state <= TBW_IDLE;
            shift <= 8'h0_0;
            bit_cnt <= 4'h0;
            phase_high <= 1'b0;
            byte_idx <= 1'b0;
            scl_out <= 1'b1;
            sda_out <= 1'b1;
            tx_req <= 1'b0;
        end else begin
            tx_req <= 1'b0;
            unique case (state)
                TBW_IDLE: begin
                    scl_out <= 1'b1;
                    sda_out <= 1'b1;
                    byte_idx <= 1'b0;
                    if (start_in) begin
                        state <= TBW_START;
                    end
                end
                TBW_START: if (tick) begin
                    sda_out <= 1'b0; // Start: data falls while clock high
                    state <= TBW_LOAD;
                end
                TBW_LOAD: if (data_full) begin
                    // Clock keeps its level (high after start, low after a byte) until software has a byte ready
                    shift <= byte_idx ? data_reg : first_byte(data_reg[2:1]); // [R1]
                    bit_cnt <= `TBW_BYTE_BITS;
                    phase_high <= 1'b0;
                    scl_out <= 1'b0;
                    state <= TBW_SHIFT;
                end
                TBW_SHIFT: if (tick) begin
                    if (!phase_high) begin
                        sda_out <= shift[7]; // [R4]
                        scl_out <= 1'b0;
                        phase_high <= 1'b1;
                    end else begin
                        scl_out <= 1'b1;
                        shift <= {shift[6:0], 1'b0};
                        bit_cnt <= bit_cnt - 4'h1;
                        phase_high <= 1'b0;
                        if (bit_cnt == `TBW_BYTE_BITS) begin
                            tx_req <= 1'b1; // [R2] [R9]
                        end
                        if (bit_cnt == 4'h1) begin
                            state <= TBW_ACK;
                        end
                    end
                end
                TBW_ACK: if (tick) begin
                    if (!phase_high) begin
                        scl_out <= 1'b0;
                        sda_out <= 1'b1; // Release data for the slave
                        phase_high <= 1'b1;
                    end else begin
                        scl_out <= 1'b1;
                        phase_high <= 1'b0;
                        state <= TBW_HOLD;
                    end
                end
                TBW_HOLD: if (tick) begin
                    scl_out <= 1'b0;
                    // Judge the live line: ack_out only takes this slot's value at this same edge
                    if (stop_out || (sda_s && byte_idx == 1'b0)) begin // [R6]
                        // Without ack, wait for software to ask for stop
                        if (stop_out) begin
                            state <= TBW_STOP_LOW; // [R8]
                        end
                    end else begin
                        byte_idx <= 1'b1;
                        state <= TBW_LOAD;
                    end
                end
                TBW_STOP_LOW: if (tick) begin
                    sda_out <= 1'b0;
                    scl_out <= 1'b0;
                    state <= TBW_STOP_HIGH;
                end
                TBW_STOP_HIGH: if (tick) begin
                    scl_out <= 1'b1;
                    state <= TBW_STOP_END;
                end
                TBW_STOP_END: if (tick) begin
                    sda_out <= 1'b1; // Stop: data rises while clock high
                    state <= TBW_IDLE;
                end
                default: state <= TBW_IDLE;
            endcase
        end
    end

    // Acknowledge sampled in the clock-high period after the byte
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            ack_out <= 1'b0;
        end else if (state == TBW_HOLD && tick) begin
            ack_out <= ~sda_s; // [R5] [R12]
        end
    end

    // No-response flag: first byte only, never when stop was asked
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            no_response_irq_flag_out <= 1'b0;
        end else if (state == TBW_HOLD && tick && sda_s && !stop_out && byte_idx == 1'b0) begin
            no_response_irq_flag_out <= 1'b1; // [R6] [R12]
        end else if (state == TBW_STOP_END && tick) begin
            no_response_irq_flag_out <= 1'b0; // [R8]
        end
    end

    // Stop bit: set by software, cleared once the stop is on the wire
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            stop_out <= 1'b0;
        end else if (stop_set_in) begin
            stop_out <= 1'b1; // Set wins over the clear [R7] [R10]
        end else if (state == TBW_STOP_END && tick) begin
            stop_out <= 1'b0; // [R11] [R8]
        end
    end

    // Transmit interrupt: level until software writes data, gated by enable
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            tx_irq_out <= 1'b0;
        end else if (tx_req) begin
            tx_irq_out <= transmit_irq_enable_in; // [R2] [R9]
        end else if (data_wr_in || !transmit_irq_enable_in || state == TBW_IDLE) begin
            tx_irq_out <= 1'b0;
        end
    end

    // Open-drain drive: enable only when pulling low
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            scl_oe_out <= 1'b0;
            sda_oe_out <= 1'b0;
            busy_out <= 1'b0;
        end else begin
            scl_oe_out <= ~scl_out;
            sda_oe_out <= ~sda_out;
            busy_out <= (state != TBW_IDLE);
        end
    end
endmodule // tbw_master

/* File: tb/tbw_master_props.sv */
// Checker for the ten-bit-address write controller
`timescale 1ns/1ps
module tbw_master_props (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic data_wr_in,
    input wire logic stop_set_in,
    input wire logic transmit_irq_enable_in,
    input wire logic sda_oe_out,
    input wire logic scl_out,
    input wire logic sda_out,
    input wire logic tx_irq_out,
    input wire logic ack_out,
    input wire logic no_response_irq_flag_out,
    input wire logic stop_out,
    input wire logic busy_out
);
    // One clock domain, so clocking and reset are given once
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    property p_irq_cause; $rose(tx_irq_out) |-> $past(transmit_irq_enable_in); endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("tx irq without enable");
    property p_irq_clear; data_wr_in |-> ##[1:2] !tx_irq_out; endproperty
    a_irq_clear: assert property (p_irq_clear) else $error("tx irq kept after data write");
    property p_nack_ack; $rose(no_response_irq_flag_out) |-> ##[0:1] !ack_out; endproperty
    a_nack_ack: assert property (p_nack_ack) else $error("ack kept on no response");
    property p_no_flag_stop; $rose(no_response_irq_flag_out) |-> !$past(stop_out); endproperty
    a_no_flag_stop: assert property (p_no_flag_stop) else $error("flag raised with stop set");
    property p_stop_done; $fell(stop_out) |-> scl_out && sda_out && $past(busy_out); endproperty
    a_stop_done: assert property (p_stop_done) else $error("stop bit cleared early");
    property p_flag_stop; $fell(no_response_irq_flag_out) |-> !stop_out && scl_out && sda_out; endproperty
    a_flag_stop: assert property (p_flag_stop) else $error("flag cleared without stop");
    property p_ack_slot; $rose(ack_out) |-> !$past(sda_oe_out) && busy_out; endproperty
    a_ack_slot: assert property (p_ack_slot) else $error("ack outside ack slot");
    property p_stop_set; stop_set_in |=> stop_out; endproperty
    a_stop_set: assert property (p_stop_set) else $error("stop request lost");
    c_ack: cover property ($rose(ack_out));
    c_flag: cover property ($rose(no_response_irq_flag_out));
    c_stop: cover property ($fell(stop_out));
endmodule // tbw_master_props

bind tbw_master tbw_master_props i_tbw_master_props (.core_clk_in, .rst_in, .data_wr_in, .stop_set_in,
    .transmit_irq_enable_in, .sda_oe_out, .scl_out, .sda_out, .tx_irq_out, .ack_out,
    .no_response_irq_flag_out, .stop_out, .busy_out);

/* File: tb/tbw_slave_model.sv */
// Behavioural two-wire slave that records the bytes it sees
`timescale 1ns/1ps
module tbw_slave_model (
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic [1:0] ack_mask_in,
    output logic sda_oe_out,
    output logic [7:0] byte0_out,
    output logic [7:0] byte1_out,
    output logic [1:0] nbytes_out
);
    logic [3:0] bit_cnt = 4'h0;
    logic [7:0] shift = 8'h00;
    initial sda_oe_out = 1'h0;
    // Start condition opens a new frame; settle first so a clock fall in the same step is not a start
    always @(negedge sda_in) begin
        #1;
        if (scl_in && !sda_in) begin
            bit_cnt = 4'h0;
            nbytes_out = 2'h0;
        end
    end
    // Data taken on clock high, first bit is the top one
    always @(posedge scl_in) begin
        bit_cnt = bit_cnt + 4'h1;
        if (bit_cnt <= 4'h8)
            shift = {shift[6:0], sda_in};
    end
    // Ack spans the whole ninth clock-high period; mask lets a scenario refuse
    always @(negedge scl_in) begin
        if (bit_cnt == 4'h8) begin
            if (nbytes_out == 2'h0)
                byte0_out = shift;
            else
                byte1_out = shift;
            sda_oe_out = ack_mask_in[nbytes_out[0]];
        end else if (bit_cnt == 4'h9) begin
            sda_oe_out = 1'h0;
            bit_cnt = 4'h0;
            nbytes_out = nbytes_out + 2'h1;
        end
    end
endmodule // tbw_slave_model

/* File: tb/tbw_master_tb.sv */
// Self-checking bench for the ten-bit-address write controller
`timescale 1ns/1ps
module tbw_master_tb;
    logic core_clk_in = 0, rst_in = 1, start_in = 0, data_wr_in = 0, stop_set_in = 0, flush_in = 0, txe = 1;
    logic [7:0] data_in = 8'h00;
    logic [1:0] ack_mask = 2'h0;
    logic scl_oe_out, sda_oe_out, scl_out, sda_out, tx_irq_out, ack_out, no_response_irq_flag_out;
    logic stop_out, busy_out, slave_oe;
    logic [7:0] byte0, byte1;
    logic [1:0] nbytes;
    int failures = 0, checks = 0;
    // Open-drain wires with pull-ups
    wire scl_in = !scl_oe_out;
    wire sda_in = !(sda_oe_out || slave_oe);
    always #2 core_clk_in = !core_clk_in;
    tbw_master i_tbw_master (.core_clk_in, .rst_in, .start_in, .data_in, .data_wr_in, .stop_set_in, .flush_in,
        .transmit_irq_enable_in(txe), .scl_in, .sda_in, .scl_oe_out, .sda_oe_out, .scl_out, .sda_out,
        .tx_irq_out, .ack_out, .no_response_irq_flag_out, .stop_out, .busy_out);
    tbw_slave_model i_tbw_slave_model (.scl_in, .sda_in, .ack_mask_in(ack_mask), .sda_oe_out(slave_oe),
        .byte0_out(byte0), .byte1_out(byte1), .nbytes_out(nbytes));
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    // One-cycle strobe: 0 start, 1 data write, 2 stop with flush in d[0]
    task automatic drive(input int sel, input logic [7:0] d);
        @(posedge core_clk_in) #1;
        data_in = d;
        case (sel)
            0: start_in = 1;
            1: data_wr_in = 1;
            default: begin
                stop_set_in = 1;
                flush_in = d[0];
                txe = 0;
            end
        endcase
        @(posedge core_clk_in) #1;
        {start_in, data_wr_in, stop_set_in, flush_in} = 4'h0;
    endtask
    // Bounded wait: 0 tx irq, 1 flag, 2 stop bit, 3 busy
    task automatic await(input int sel, input logic v);
        logic s;
        for (int i = 0; i < 40000; i++) begin
            @(posedge core_clk_in) #1;
            s = sel == 0 ? tx_irq_out : sel == 1 ? no_response_irq_flag_out : sel == 2 ? stop_out : busy_out;
            if (s === v)
                return;
        end
        failures++;
        $display("mismatch wait %0d expected %b seen %b", sel, v, s);
    endtask
    task automatic run(input string name, input logic [1:0] mask, input logic [9:0] addr);
        ack_mask = mask;
        txe = 1;
        await(3, 0);
        drive(0, 8'h00);
        drive(1, {5'h00, addr[9:8], 1'h0});
        await(0, 1);
        drive(1, addr[7:0]);
        if (mask[0]) begin
            await(0, 1);
            drive(2, 8'h00);
            await(2, 0);
            chk("ack", {7'h00, mask[1]}, {7'h00, ack_out});
            chk("byte1", addr[7:0], byte1);
        end else begin
            await(1, 1);
            chk("ack", 8'h00, {7'h00, ack_out});
            drive(2, 8'h01);
            await(2, 0);
            chk("nbytes", 8'h01, {6'h00, nbytes});
        end
        chk("flag", 8'h00, {7'h00, no_response_irq_flag_out});
        chk("bus", 8'h03, {6'h00, scl_out, sda_out});
        chk("byte0", {5'h1E, addr[9:8], 1'h0}, byte0);
        $display("test %s done", name);
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge core_clk_in);
        #1 rst_in = 0;
        run("ack", 2'h3, 10'h2B5);
        run("nack", 2'h0, 10'h14A);
        run("last_nack", 2'h1, 10'h30F);
        summarize();
    end
    // Three transfers take about 54k cycles
    initial begin
        #400_000;
        failures++;
        summarize();
    end
endmodule // tbw_master_tb
